//--- design/lcdcd_defines.svh
// Purpose: Opcode masks, field values and reset values of the display command decoder
// Assumes: Commands matched as (byte & mask) == value
// Notes:   Masks clear the don't-care bits of each encoding
//
// Operation
// - Byte 001xxxxx sets mirrors, power-down, page
// - Display memory reads impossible over serial link
// - Page 0 burst count over three commands
// - Low burst count starts data byte phase
// - Page 0 nibble 0100 loads RAM page
// - Page 0 nibbles 1110/1111 load column address
// - Page 0 range, modify-write, end, display config
// - Page 1 byte 000100xx loads bias ratio
// - Page 1 prefix 01000 loads power enables
// - Page 1 pump stages and seven-bit contrast
// - Page 2 byte 0000010x sets partial mode
// - Page 2 byte 0000100x loads partial size
// - Page 2 nibble 0001 loads partial window
// - Page 2 bit 7 loads start line
// - Page 3 prefix 010 loads inversion lines
// - Page 3 soft reset, scan rate, reserved
// - Don't-care command bits are ignored
// - Reset pin low initialises all state
`ifndef LCDCD_DEFINES_SVH
`define LCDCD_DEFINES_SVH

`define LCDCD_CMD_LAST   4'h8
`define LCDCD_DATA_LAST  4'h7

`define LCDCD_M_FSET     8'he0
`define LCDCD_V_FSET     8'h20
`define LCDCD_M_VOPR     8'hfe
`define LCDCD_V_VOPR     8'h04
`define LCDCD_M_RMW      8'hff
`define LCDCD_V_RMW_ON   8'h07
`define LCDCD_V_RMW_OFF  8'h06
`define LCDCD_M_DISP     8'hfa
`define LCDCD_V_DISP     8'h08
`define LCDCD_M_NIB      8'hf0
`define LCDCD_V_CNT_L    8'h50
`define LCDCD_V_CNT_M    8'h60
`define LCDCD_M_CNT_H    8'hf8
`define LCDCD_V_CNT_H    8'h70
`define LCDCD_V_YPAGE    8'h40
`define LCDCD_V_COL_L    8'he0
`define LCDCD_V_COL_H    8'hf0
`define LCDCD_M_BIAS     8'hfc
`define LCDCD_V_BIAS     8'h10
`define LCDCD_M_PWR      8'hf8
`define LCDCD_V_PWR      8'h40
`define LCDCD_M_BOOST    8'hfc
`define LCDCD_V_BOOST    8'h64
`define LCDCD_M_B7       8'h80
`define LCDCD_V_B7       8'h80
`define LCDCD_M_PSM      8'hfe
`define LCDCD_V_PSM      8'h04
`define LCDCD_V_PSIZE    8'h08
`define LCDCD_V_PWIN     8'h10
`define LCDCD_M_SRST     8'hff
`define LCDCD_V_SRST     8'h03
`define LCDCD_M_FRATE    8'hf8
`define LCDCD_V_FRATE    8'h08
`define LCDCD_M_NLINE    8'he0
`define LCDCD_V_NLINE    8'h40
`define LCDCD_M_RSVD     8'hfe
`define LCDCD_V_RSVD     8'h10

`define LCDCD_CONTRAST_RST 7'h00
`define LCDCD_BIAS_RST     2'h0

`endif

//--- design/lcdcd_pkg.sv
// Purpose: Types of the display command decoder
// Assumes: Constants live in lcdcd_defines.svh
// Notes:   Link receiver states are Gray along CMD -> DATA
package lcdcd_pkg;
  typedef enum logic [1:0] {
    LCDCD_RX_CMD  = 2'b00,
    LCDCD_RX_DATA = 2'b01
  } lcdcd_rx_state_e;
  typedef logic [1:0]  lcdcd_page_t;
  typedef logic [10:0] lcdcd_count_t;
endpackage

//--- design/lcdcd_word_if.sv
// Purpose: Received word carrier from link domain to system domain
// Assumes: tgl flips once per word; other fields stable until next flip
// Notes:   Words arrive no faster than one per eight link clocks
`timescale 1ns/10ps
`default_nettype none
interface lcdcd_word_if;
  logic       tgl;
  logic [7:0] wbyte;
  logic       is_data;
  logic       rw;
  modport rx  (output tgl, output wbyte, output is_data, output rw);
  modport dec (input tgl, input wbyte, input is_data, input rw);
endinterface
`default_nettype wire

//--- design/lcdcd_serial_rx.sv
// Purpose: Three-line serial receiver on the link clock
// Assumes: Nine-bit command frames, eight-bit frames in data phase
// Notes:   Select high clears the bit counter asynchronously
`timescale 1ns/10ps
`default_nettype none
`include "lcdcd_defines.svh"
module lcdcd_serial_rx (
  input  wire logic     scl_i,      // Link clock
  input  wire logic     rstn_i,     // Async reset, low
  input  wire logic     select_n_i, // Chip select, low
  input  wire logic     sda_i,      // Serial data
  lcdcd_word_if.rx      lnk         // Word toward decoder
);
  lcdcd_pkg::lcdcd_rx_state_e state;
  lcdcd_pkg::lcdcd_page_t     page;
  logic [3:0]                 bit_cnt;
  logic [7:0]                 shift;
  logic [3:0]                 cnt_mid;
  logic [2:0]                 cnt_high;
  lcdcd_pkg::lcdcd_count_t    remain;

  wire       frame_rst_n = rstn_i & ~select_n_i;
  wire       in_data     = (state == lcdcd_pkg::LCDCD_RX_DATA);
  wire [3:0] last_bit    = in_data ? `LCDCD_DATA_LAST : `LCDCD_CMD_LAST;
  wire       done        = (bit_cnt == last_bit);
  wire [7:0] rx_byte     = {shift[6:0], sda_i};
  wire       rx_a0       = in_data | shift[7];
  wire       cmd_done    = done & ~rx_a0;
  wire       pg0         = (page == 2'h0);
  wire       hit_fs      = (rx_byte & `LCDCD_M_FSET) == `LCDCD_V_FSET;
  wire       hit_m       = pg0 & ((rx_byte & `LCDCD_M_NIB) == `LCDCD_V_CNT_M);
  wire       hit_h       = pg0 & ((rx_byte & `LCDCD_M_CNT_H) == `LCDCD_V_CNT_H);
  wire       hit_l       = pg0 & ((rx_byte & `LCDCD_M_NIB) == `LCDCD_V_CNT_L);
  wire [10:0] burst      = {cnt_high, cnt_mid, rx_byte[3:0]};

  assign lnk.rw = 1'b0; // Serial host cannot read

  always_ff @(posedge scl_i or negedge frame_rst_n)
  begin
    if (!frame_rst_n) bit_cnt <= 4'h0;
    else bit_cnt <= done ? 4'h0 : bit_cnt + 4'h1;
  end

  always_ff @(posedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      shift       <= 8'h00;
      lnk.tgl     <= 1'b0;
      lnk.wbyte   <= 8'h00;
      lnk.is_data <= 1'b0;
    end
    else
    begin
      shift <= rx_byte;
      if (done)
      begin
        lnk.tgl     <= ~lnk.tgl;
        lnk.wbyte   <= rx_byte;
        lnk.is_data <= rx_a0;
      end
    end
  end

  always_ff @(posedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state    <= lcdcd_pkg::LCDCD_RX_CMD;
      page     <= 2'h0;
      cnt_mid  <= 4'h0;
      cnt_high <= 3'h0;
      remain   <= 11'h000;
    end
    else if (cmd_done)
    begin
      if (hit_fs) page <= rx_byte[1:0];
      else if (hit_m) cnt_mid <= rx_byte[3:0];
      else if (hit_h) cnt_high <= rx_byte[2:0];
      else if (hit_l)
      begin
        remain <= burst;
        state  <= (burst != 11'h000) ? lcdcd_pkg::LCDCD_RX_DATA : lcdcd_pkg::LCDCD_RX_CMD;
      end
    end
    else if (done && in_data)
    begin
      remain <= remain - 11'h001;
      if (remain == 11'h001) state <= lcdcd_pkg::LCDCD_RX_CMD;
    end
  end
endmodule
`default_nettype wire

//--- design/lcdcd_decoder.sv
// Purpose: Command decoder of the dot-matrix display driver
// Assumes: Serial words arrive through lcdcd_serial_rx on the link clock
// Notes:   All settings are outputs held in flip-flops
`timescale 1ns/10ps
`default_nettype none
`include "lcdcd_defines.svh"
module lcdcd_decoder (
  input  wire logic        clock_i,              // System clock, 40 MHz
  input  wire logic        rstn_i,               // Async reset, low
  input  wire logic        scl_i,                // Serial link clock
  input  wire logic        select_n_i,           // Chip select, low
  input  wire logic        sda_i,                // Serial data
  output var  logic        power_down_o,         // Power-down
  output var  logic        column_mirror_o,      // Column mirror
  output var  logic        row_mirror_o,         // Row mirror
  output var  logic [1:0]  page_o,               // Instruction page
  output var  logic        vop_range_sel_o,      // Drive voltage range
  output var  logic        rmw_active_o,         // Modify-write mode
  output var  logic [1:0]  display_cfg_o,        // Display config bits
  output var  logic [10:0] burst_byte_count_o,   // Data byte count
  output var  logic        data_phase_o,         // Data phase active
  output var  logic [3:0]  ram_page_o,           // RAM page address
  output var  logic [7:0]  ram_col_o,            // RAM column address
  output var  logic        ram_wr_o,             // RAM write pulse
  output var  logic [7:0]  ram_wdata_o,          // RAM write data
  output var  logic [7:0]  ram_wr_col_o,         // Column of the write
  output var  logic [3:0]  ram_wr_page_o,        // Page of the write
  output var  logic [1:0]  bias_ratio_o,         // Bias ratio
  output var  logic        converter_on_o,       // Converter enable
  output var  logic        regulator_on_o,       // Regulator enable
  output var  logic        follower_on_o,        // Follower enable
  output var  logic [1:0]  pump_stages_o,        // Booster stages
  output var  logic [6:0]  contrast_code_o,      // Contrast code
  output var  logic        partial_mode_en_o,    // Partial mode
  output var  logic        partial_size_sel_o,   // Partial size
  output var  logic [3:0]  partial_window_sel_o, // Partial window
  output var  logic [6:0]  start_line_o,         // Scroll start line
  output var  logic [4:0]  inversion_lines_o,    // N-line inversion
  output var  logic [2:0]  panel_scan_rate_o,    // Frame rate
  output var  logic        soft_reinit_o         // Soft reset pulse
);

  // ----------------------------------------
  // Link receiver and word crossing
  // ----------------------------------------
  lcdcd_word_if lnk ();

  lcdcd_serial_rx u_rx (
    .scl_i      (scl_i),
    .rstn_i     (rstn_i),
    .select_n_i (select_n_i),
    .sda_i      (sda_i),
    .lnk        (lnk)
  );

  logic       tgl_s1;
  logic       tgl_s2;
  logic       tgl_s3;
  logic       go;
  logic [7:0] word;
  logic       word_data;
  logic       word_rw;
  logic [3:0] cnt_mid;
  logic [2:0] cnt_high;

  wire evt = tgl_s2 ^ tgl_s3;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end
    else
    begin
      tgl_s1 <= lnk.tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // Word fields have been stable since the tgl flip, at least one system clock, when evt fires
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      go        <= 1'b0;
      word      <= 8'h00;
      word_data <= 1'b0;
      word_rw   <= 1'b0;
    end
    else
    begin
      go <= evt;
      if (evt)
      begin
        word      <= lnk.wbyte;
        word_data <= lnk.is_data;
        word_rw   <= lnk.rw;
      end
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  function automatic logic op_is(input logic [7:0] b, input logic [7:0] m,
                                 input logic [7:0] v);
    op_is = ((b & m) == v);
  endfunction

  wire cmd_wr  = go & ~word_data & ~word_rw;
  wire data_wr = go & word_data & ~word_rw;
  wire data_rd = go & word_data & word_rw;
  wire hit_fs  = cmd_wr & op_is(word, `LCDCD_M_FSET, `LCDCD_V_FSET);
  wire pc      = cmd_wr & ~hit_fs;
  wire pg0     = pc & (page_o == 2'h0);
  wire pg1     = pc & (page_o == 2'h1);
  wire pg2     = pc & (page_o == 2'h2);
  wire pg3     = pc & (page_o == 2'h3);

  wire hit_vopr  = pg0 & op_is(word, `LCDCD_M_VOPR, `LCDCD_V_VOPR);
  wire hit_rmw   = pg0 & op_is(word, `LCDCD_M_RMW, `LCDCD_V_RMW_ON);
  wire hit_end   = pg0 & op_is(word, `LCDCD_M_RMW, `LCDCD_V_RMW_OFF);
  wire hit_disp  = pg0 & op_is(word, `LCDCD_M_DISP, `LCDCD_V_DISP);
  wire hit_cnt_l = pg0 & op_is(word, `LCDCD_M_NIB, `LCDCD_V_CNT_L);
  wire hit_cnt_m = pg0 & op_is(word, `LCDCD_M_NIB, `LCDCD_V_CNT_M);
  wire hit_cnt_h = pg0 & op_is(word, `LCDCD_M_CNT_H, `LCDCD_V_CNT_H);
  wire hit_ypage = pg0 & op_is(word, `LCDCD_M_NIB, `LCDCD_V_YPAGE);
  wire hit_col_l = pg0 & op_is(word, `LCDCD_M_NIB, `LCDCD_V_COL_L);
  wire hit_col_h = pg0 & op_is(word, `LCDCD_M_NIB, `LCDCD_V_COL_H);
  wire hit_bias  = pg1 & op_is(word, `LCDCD_M_BIAS, `LCDCD_V_BIAS);
  wire hit_pwr   = pg1 & op_is(word, `LCDCD_M_PWR, `LCDCD_V_PWR);
  wire hit_boost = pg1 & op_is(word, `LCDCD_M_BOOST, `LCDCD_V_BOOST);
  wire hit_contr = pg1 & op_is(word, `LCDCD_M_B7, `LCDCD_V_B7);
  wire hit_psm   = pg2 & op_is(word, `LCDCD_M_PSM, `LCDCD_V_PSM);
  wire hit_psize = pg2 & op_is(word, `LCDCD_M_PSM, `LCDCD_V_PSIZE);
  wire hit_pwin  = pg2 & op_is(word, `LCDCD_M_NIB, `LCDCD_V_PWIN);
  wire hit_start = pg2 & op_is(word, `LCDCD_M_B7, `LCDCD_V_B7);
  wire hit_srst  = pg3 & op_is(word, `LCDCD_M_SRST, `LCDCD_V_SRST);
  wire hit_frate = pg3 & op_is(word, `LCDCD_M_FRATE, `LCDCD_V_FRATE);
  wire hit_nline = pg3 & op_is(word, `LCDCD_M_NLINE, `LCDCD_V_NLINE);

  wire [10:0] burst    = {cnt_high, cnt_mid, word[3:0]};
  // Modify-write holds the column on reads, every write steps it
  wire        col_step = data_wr | (data_rd & ~rmw_active_o);
  wire [7:0]  next_col = ram_col_o + 8'h01;

  // ----------------------------------------
  // Basic and page 0 state
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      power_down_o    <= 1'b0;
      column_mirror_o <= 1'b0;
      row_mirror_o    <= 1'b0;
      page_o          <= 2'h0;
    end
    else if (hit_fs)
    begin
      column_mirror_o <= word[4];
      row_mirror_o    <= word[3];
      power_down_o    <= word[2];
      page_o          <= word[1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      vop_range_sel_o <= 1'b0;
      rmw_active_o    <= 1'b0;
      display_cfg_o   <= 2'h0;
    end
    else if (hit_srst)
    begin
      vop_range_sel_o <= 1'b0;
      rmw_active_o    <= 1'b0;
      display_cfg_o   <= 2'h0;
    end
    else
    begin
      if (hit_vopr) vop_range_sel_o <= word[0];
      if (hit_rmw) rmw_active_o <= 1'b1;
      else if (hit_end) rmw_active_o <= 1'b0;
      if (hit_disp) display_cfg_o <= {word[2], word[0]};
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_mid            <= 4'h0;
      cnt_high           <= 3'h0;
      burst_byte_count_o <= 11'h000;
      data_phase_o       <= 1'b0;
    end
    else
    begin
      if (hit_cnt_m) cnt_mid <= word[3:0];
      if (hit_cnt_h) cnt_high <= word[2:0];
      if (hit_cnt_l)
      begin
        burst_byte_count_o <= burst;
        data_phase_o       <= (burst != 11'h000);
      end
      else if (data_wr && data_phase_o)
      begin
        burst_byte_count_o <= burst_byte_count_o - 11'h001;
        if (burst_byte_count_o == 11'h001) data_phase_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Display memory addressing and writes
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ram_page_o <= 4'h0;
      ram_col_o  <= 8'h00;
    end
    else
    begin
      if (hit_ypage) ram_page_o <= word[3:0];
      if (hit_col_l) ram_col_o[3:0] <= word[3:0];
      else if (hit_col_h) ram_col_o[7:4] <= word[3:0];
      else if (col_step) ram_col_o <= next_col;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ram_wr_o      <= 1'b0;
      ram_wdata_o   <= 8'h00;
      ram_wr_col_o  <= 8'h00;
      ram_wr_page_o <= 4'h0;
    end
    else
    begin
      ram_wr_o <= data_wr;
      if (data_wr)
      begin
        ram_wdata_o   <= word;
        ram_wr_col_o  <= ram_col_o;
        ram_wr_page_o <= ram_page_o;
      end
    end
  end

  // ----------------------------------------
  // Pages 1 to 3 settings
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bias_ratio_o    <= `LCDCD_BIAS_RST;
      converter_on_o  <= 1'b0;
      regulator_on_o  <= 1'b0;
      follower_on_o   <= 1'b0;
      pump_stages_o   <= 2'h0;
      contrast_code_o <= `LCDCD_CONTRAST_RST;
    end
    else if (hit_srst)
    begin
      bias_ratio_o    <= `LCDCD_BIAS_RST;
      converter_on_o  <= 1'b0;
      regulator_on_o  <= 1'b0;
      follower_on_o   <= 1'b0;
      pump_stages_o   <= 2'h0;
      contrast_code_o <= `LCDCD_CONTRAST_RST;
    end
    else
    begin
      if (hit_bias) bias_ratio_o <= word[1:0];
      if (hit_pwr)
      begin
        converter_on_o <= word[2];
        regulator_on_o <= word[1];
        follower_on_o  <= word[0];
      end
      if (hit_boost) pump_stages_o <= word[1:0];
      if (hit_contr) contrast_code_o <= word[6:0];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      partial_mode_en_o    <= 1'b0;
      partial_size_sel_o   <= 1'b0;
      partial_window_sel_o <= 4'h0;
      start_line_o         <= 7'h00;
      inversion_lines_o    <= 5'h00;
      panel_scan_rate_o    <= 3'h0;
      soft_reinit_o        <= 1'b0;
    end
    else
    begin
      soft_reinit_o <= hit_srst;
      if (hit_srst)
      begin
        partial_mode_en_o    <= 1'b0;
        partial_size_sel_o   <= 1'b0;
        partial_window_sel_o <= 4'h0;
        start_line_o         <= 7'h00;
        inversion_lines_o    <= 5'h00;
        panel_scan_rate_o    <= 3'h0;
      end
      else
      begin
        if (hit_psm) partial_mode_en_o <= word[0];
        if (hit_psize) partial_size_sel_o <= word[0];
        if (hit_pwin) partial_window_sel_o <= word[3:0];
        if (hit_start) start_line_o <= word[6:0];
        if (hit_nline) inversion_lines_o <= word[4:0];
        if (hit_frate) panel_scan_rate_o <= word[2:0];
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  property p_fs_page;
    hit_fs |=> (page_o == $past(word[1:0])) && (power_down_o == $past(word[2]));
  endproperty
  a_fs_page: assert property (p_fs_page) else $error("function set not applied");

  property p_no_read_write;
    data_wr |=> ram_wr_o && (ram_wdata_o == $past(word));
  endproperty
  a_no_read_write: assert property (p_no_read_write) else $error("data byte not written");

  property p_burst;
    hit_cnt_l |=> burst_byte_count_o == {$past(cnt_high), $past(cnt_mid), $past(word[3:0])};
  endproperty
  a_burst: assert property (p_burst) else $error("burst count wrong");

  property p_data_phase;
    hit_cnt_l && (word[3:0] != 4'h0) |=> data_phase_o;
  endproperty
  a_data_phase: assert property (p_data_phase) else $error("data phase not started");

  property p_ypage;
    hit_ypage |=> ram_page_o == $past(word[3:0]);
  endproperty
  a_ypage: assert property (p_ypage) else $error("page address not loaded");

  property p_col_high;
    hit_col_h |=> ram_col_o[7:4] == $past(word[3:0]);
  endproperty
  a_col_high: assert property (p_col_high) else $error("column high not loaded");

  property p_write_step;
    data_wr && !hit_col_l && !hit_col_h |=> ram_wr_o && (ram_col_o == ram_wr_col_o + 8'h01);
  endproperty
  a_write_step: assert property (p_write_step) else $error("column not stepped");

  property p_bias;
    hit_bias |=> bias_ratio_o == $past(word[1:0]);
  endproperty
  a_bias: assert property (p_bias) else $error("bias not loaded");

  property p_contrast;
    hit_contr |=> contrast_code_o == $past(word[6:0]);
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast not loaded");

  property p_start_line;
    hit_start |=> start_line_o == $past(word[6:0]);
  endproperty
  a_start_line: assert property (p_start_line) else $error("start line not loaded");

  property p_soft_reinit;
    hit_srst |=> soft_reinit_o ##1 (!soft_reinit_o && contrast_code_o == `LCDCD_CONTRAST_RST);
  endproperty
  a_soft_reinit: assert property (p_soft_reinit) else $error("soft reset wrong");

  property p_page_hold;
    !hit_fs |=> $stable(page_o);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed");

  c_fs: cover property (hit_fs ##[1:400] hit_cnt_l);
  c_burst_write: cover property (data_phase_o ##[1:200] ram_wr_o);
  c_srst: cover property (hit_srst);
endmodule
`default_nettype wire

//--- tb/lcdcd_host_model.sv
// Purpose: Host model driving the three-line serial link
// Assumes: Link clock period 48 ns, still and low between frames
// Notes:   Data line inverts once the frame ends
`timescale 1ns/10ps
`default_nettype none
module lcdcd_host_model (
  output var logic scl_o,      // Link clock
  output var logic select_n_o, // Chip select, low
  output var logic sda_o       // Serial data
);
  // --------------------
  // Frame sender
  // --------------------
  initial
  begin
    scl_o = 1'b0;
    select_n_o = 1'b1;
    sda_o = 1'b0;
  end
  // Frame of n bits, MSB first; stops after k bits
  task automatic send(input logic [8:0] f, input int n, input int k);
    select_n_o = 1'b0;
    for (int i = 0; i < k; i++)
    begin
      sda_o = f[n-1-i];
      #24 scl_o = 1'b1;
      #24 scl_o = 1'b0;
    end
    #24 select_n_o = 1'b1;
    sda_o = ~sda_o;
    #48;
  endtask
endmodule
`default_nettype wire

//--- tb/lcdcd_decoder_tb.sv
// Purpose: Self-checking bench of the display command decoder
// Assumes: Host model sends only defined command codes
// Notes:   Each check waits six system clocks after a frame
`timescale 1ns/10ps
`default_nettype none
module lcdcd_decoder_tb;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic scl_i, select_n_i, sda_i;
  logic power_down_o, column_mirror_o, row_mirror_o, vop_range_sel_o, rmw_active_o;
  logic data_phase_o, ram_wr_o, converter_on_o, regulator_on_o, follower_on_o;
  logic partial_mode_en_o, partial_size_sel_o, soft_reinit_o;
  logic [1:0] page_o, display_cfg_o, bias_ratio_o, pump_stages_o;
  logic [10:0] burst_byte_count_o;
  logic [3:0] ram_page_o, ram_wr_page_o, partial_window_sel_o;
  logic [7:0] ram_col_o, ram_wdata_o, ram_wr_col_o;
  logic [6:0] contrast_code_o, start_line_o;
  logic [4:0] inversion_lines_o;
  logic [2:0] panel_scan_rate_o;
  int err_count = 0;
  int checked = 0;
  int wr_n = 0;
  int sr_n = 0;
  // --------------------
  // Design and host
  // --------------------
  lcdcd_decoder lcdcd_decoder_inst (.clock_i, .rstn_i, .scl_i, .select_n_i, .sda_i,
    .power_down_o, .column_mirror_o, .row_mirror_o, .page_o, .vop_range_sel_o,
    .rmw_active_o, .display_cfg_o, .burst_byte_count_o, .data_phase_o, .ram_page_o,
    .ram_col_o, .ram_wr_o, .ram_wdata_o, .ram_wr_col_o, .ram_wr_page_o, .bias_ratio_o,
    .converter_on_o, .regulator_on_o, .follower_on_o, .pump_stages_o, .contrast_code_o,
    .partial_mode_en_o, .partial_size_sel_o, .partial_window_sel_o, .start_line_o,
    .inversion_lines_o, .panel_scan_rate_o, .soft_reinit_o);
  lcdcd_host_model lcdcd_host_model_inst (.scl_o(scl_i), .select_n_o(select_n_i),
    .sda_o(sda_i));
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    if (ram_wr_o === 1'b1)
      wr_n <= wr_n + 1;
    if (soft_reinit_o === 1'b1)
      sr_n <= sr_n + 1;
  end
  // --------------------
  // Helpers
  // --------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    lcdcd_host_model_inst.send({1'b0, b}, 9, 9);
    repeat (6) @(posedge clock_i);
  endtask
  task automatic dat(input logic [7:0] b);
    lcdcd_host_model_inst.send({1'b0, b}, 8, 8);
    repeat (6) @(posedge clock_i);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset();
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(page_o, 0);
    chk(contrast_code_o, 0);
    chk(data_phase_o, 0);
  endtask
  task automatic t_page1();
    cmd(8'h3d);
    chk({column_mirror_o, row_mirror_o, power_down_o, page_o}, 5'h1d);
    cmd(8'h13);
    cmd(8'h45);
    cmd(8'h66);
    cmd(8'hd5);
    chk(bias_ratio_o, 3);
    chk({converter_on_o, regulator_on_o, follower_on_o}, 3'h5);
    chk(pump_stages_o, 2);
    chk(contrast_code_o, 7'h55);
  endtask
  task automatic t_page2();
    cmd(8'h22);
    cmd(8'h05);
    cmd(8'h09);
    cmd(8'h1a);
    cmd(8'h93);
    chk(page_o, 2);
    chk(partial_mode_en_o, 1);
    chk(partial_size_sel_o, 1);
    chk(partial_window_sel_o, 4'ha);
    chk(start_line_o, 7'h13);
  endtask
  task automatic t_page3();
    cmd(8'h23);
    cmd(8'h0d);
    cmd(8'h55);
    cmd(8'h11);
    cmd(8'h10);
    chk(panel_scan_rate_o, 5);
    chk(inversion_lines_o, 5'h15);
    cmd(8'h03);
    chk(sr_n, 1);
    chk({contrast_code_o, inversion_lines_o, panel_scan_rate_o}, 0);
    chk(page_o, 3);
  endtask
  task automatic t_page0();
    cmd(8'h20);
    cmd(8'h47);
    cmd(8'he3);
    cmd(8'hf2);
    cmd(8'h05);
    cmd(8'h0d);
    cmd(8'h07);
    chk(ram_page_o, 7);
    chk(ram_col_o, 8'h23);
    chk({vop_range_sel_o, display_cfg_o, rmw_active_o}, 4'hf);
    cmd(8'h06);
    chk(rmw_active_o, 0);
  endtask
  task automatic t_burst();
    cmd(8'h70);
    cmd(8'h6a);
    cmd(8'h5b);
    chk(burst_byte_count_o, 11'h0ab);
    chk(data_phase_o, 1);
    dat(8'ha5);
    chk({ram_wdata_o, ram_wr_page_o}, 12'ha57);
    chk({ram_wr_col_o, ram_col_o}, 16'h2324);
    chk(burst_byte_count_o, 11'h0aa);
    for (int i = 1; i < 171; i++)
      dat(i[7:0]);
    chk(data_phase_o, 0);
    chk(ram_col_o, 8'hce);
    chk(wr_n, 171);
  endtask
  task automatic t_abort();
    lcdcd_host_model_inst.send({1'b0, 8'h4f}, 9, 4);
    cmd(8'h41);
    chk(ram_page_o, 1);
    chk(page_o, 0);
  endtask
  task automatic t_rerun();
    rstn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk({ram_page_o, ram_col_o}, 0);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    cmd(8'h44);
    chk(ram_page_o, 4);
  endtask
  initial
  begin
    #400000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    t_reset();
    t_page1();
    t_page2();
    t_page3();
    t_page0();
    t_burst();
    t_abort();
    t_rerun();
    report_and_stop();
  end
endmodule
`default_nettype wire
